// File: hdl/dppa_pkg.sv
package dppa_pkg;
  // register select codes on the two pick lines
  localparam logic [1:0] DPPA_SEL_A_PORT = 2'h0;
  localparam logic [1:0] DPPA_SEL_A_CTL  = 2'h1;
  localparam logic [1:0] DPPA_SEL_B_PORT = 2'h2;
  localparam logic [1:0] DPPA_SEL_B_CTL  = 2'h3;
  // control register field positions
  localparam int DPPA_CTL_FLAG_FIRST  = 7;
  localparam int DPPA_CTL_FLAG_SECOND = 6;
  localparam int DPPA_CTL_IO_MODE     = 5;
  localparam int DPPA_CTL_IO_EDGE     = 4;
  localparam int DPPA_CTL_IO_ENABLE   = 3;
  localparam int DPPA_CTL_OUT_ACCESS  = 2;
  localparam int DPPA_CTL_IN_EDGE     = 1;
  localparam int DPPA_CTL_IN_ENABLE   = 0;
  localparam logic [7:0] DPPA_CTL_WRITE_MASK = 8'h3f;
  // reset values
  localparam logic [7:0] DPPA_RESET_VALUE = 8'h00;
endpackage

// File: hdl/dppa_port.sv
`timescale 1ns/10ps
// one port section: control, direction and output registers, line events
module dppa_port
  import dppa_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_wr_ctl,
  input  wire logic             i_wr_dir,
  input  wire logic             i_wr_out,
  input  wire logic             i_rd_out,
  input  wire logic [7:0]       i_wdata,
  input  wire logic [WIDTH-1:0] i_lines,
  input  wire logic             i_ctl_in,
  input  wire logic             i_ctl_io,
  output logic      [7:0]       o_ctl,
  output logic      [WIDTH-1:0] o_dir,
  output logic      [WIDTH-1:0] o_out,
  output logic      [WIDTH-1:0] o_read_value,
  output logic                  o_irq_n
);
  // only the byte-wide port is built; another width would need a new read path
  if (WIDTH != 8) begin : g_width_check
    $error("dppa_port: only 8-bit ports are served");
  end

  logic       ctl_in_prev_reg;
  logic       ctl_io_prev_reg;
  logic [7:0] ctl_reg;
  logic       edge_first;
  logic       edge_second;

  // previous line levels for edge detection
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctl_in_prev_reg <= 1'b0;
      ctl_io_prev_reg <= 1'b0;
    end else begin
      ctl_in_prev_reg <= i_ctl_in;
      ctl_io_prev_reg <= i_ctl_io;
    end
  end

  // bit set: rising edge, clear: falling edge
  assign edge_first  = ctl_reg[DPPA_CTL_IN_EDGE] ? (i_ctl_in & ~ctl_in_prev_reg)
                                                 : (~i_ctl_in & ctl_in_prev_reg);
  assign edge_second = ~ctl_reg[DPPA_CTL_IO_MODE] &
                       (ctl_reg[DPPA_CTL_IO_EDGE] ? (i_ctl_io & ~ctl_io_prev_reg)
                                                  : (~i_ctl_io & ctl_io_prev_reg));

  // flags: an edge in the same cycle as the clearing read wins
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctl_reg <= DPPA_RESET_VALUE;
    end else begin
      if (i_wr_ctl) begin
        ctl_reg[5:0] <= i_wdata[5:0];
      end
      if (edge_first) begin
        ctl_reg[DPPA_CTL_FLAG_FIRST] <= 1'b1;
      end else if (i_rd_out) begin
        ctl_reg[DPPA_CTL_FLAG_FIRST] <= 1'b0;
      end
      if (edge_second) begin
        ctl_reg[DPPA_CTL_FLAG_SECOND] <= 1'b1;
      end else if (i_rd_out) begin
        ctl_reg[DPPA_CTL_FLAG_SECOND] <= 1'b0;
      end
    end
  end
  assign o_ctl = ctl_reg;

  // direction and output registers
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_dir <= WIDTH'(DPPA_RESET_VALUE);
      o_out <= WIDTH'(DPPA_RESET_VALUE);
    end else begin
      if (i_wr_dir) o_dir <= i_wdata[WIDTH-1:0];
      if (i_wr_out) o_out <= i_wdata[WIDTH-1:0];
    end
  end

  // inputs read the pins, outputs read back the output register
  assign o_read_value = (i_lines & ~o_dir) | (o_out & o_dir);

  // request from a registered flag term, so it starts one cycle after the flag
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_irq_n <= 1'b1;
    end else begin
      o_irq_n <= ~((ctl_reg[DPPA_CTL_FLAG_FIRST] & ctl_reg[DPPA_CTL_IN_ENABLE]) |
                   (ctl_reg[DPPA_CTL_FLAG_SECOND] & ctl_reg[DPPA_CTL_IO_ENABLE]));
    end
  end

  flag_set_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    edge_first |=> ctl_reg[DPPA_CTL_FLAG_FIRST])
    else $error("first flag not set by edge");
  flag_clear_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (i_rd_out && !edge_first) |=> !ctl_reg[DPPA_CTL_FLAG_FIRST])
    else $error("first flag not cleared by read");
  irq_gate_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (ctl_reg[DPPA_CTL_FLAG_FIRST] && ctl_reg[DPPA_CTL_IN_ENABLE]) |=> !o_irq_n)
    else $error("request not raised");
  irq_quiet_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (!ctl_reg[DPPA_CTL_IN_ENABLE] && !ctl_reg[DPPA_CTL_IO_ENABLE]) |=> o_irq_n)
    else $error("masked request raised");
  flag_second_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    edge_second |=> ctl_reg[DPPA_CTL_FLAG_SECOND])
    else $error("second flag not set by edge");
  flag_readonly_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (i_wr_ctl && !edge_first && !i_rd_out) |=>
      (ctl_reg[DPPA_CTL_FLAG_FIRST] == $past(ctl_reg[DPPA_CTL_FLAG_FIRST])))
    else $error("first flag changed by control write");
endmodule

// File: hdl/dppa_top.sv
`timescale 1ns/10ps
module dppa_top
  import dppa_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_select_high_first,
  input  wire logic       i_select_high_second,
  input  wire logic       i_select_low_n,
  input  wire logic       i_read_not_write,
  input  wire logic       i_reg_pick_low,
  input  wire logic       i_reg_pick_high,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe_n,
  input  wire logic [7:0] i_port_a_lines,
  output logic      [7:0] o_port_a_lines,
  output logic      [7:0] o_port_a_lines_oe_n,
  input  wire logic [7:0] i_port_b_lines,
  output logic      [7:0] o_port_b_lines,
  output logic      [7:0] o_port_b_lines_oe_n,
  input  wire logic       i_port_a_ctl_in,
  input  wire logic       i_port_a_ctl_io,
  input  wire logic       i_port_b_ctl_in,
  input  wire logic       i_port_b_ctl_io,
  output logic            o_port_a_irq_n,
  output logic            o_port_b_irq_n
);
  logic       selected;
  logic [1:0] pick;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] ctl_a;
  logic [7:0] ctl_b;
  logic [7:0] dir_a;
  logic [7:0] dir_b;
  logic [7:0] out_a;
  logic [7:0] out_b;
  logic [7:0] rv_a;
  logic [7:0] rv_b;
  logic       irq_a_n;
  logic       irq_b_n;
  logic       wr_ctl_a;
  logic       wr_ctl_b;
  logic       wr_dir_a;
  logic       wr_dir_b;
  logic       wr_out_a;
  logic       wr_out_b;
  logic       rd_out_a;
  logic       rd_out_b;
  logic [7:0] rdata_next;

  // chip select decode; one access per bus clock cycle
  assign selected = i_select_high_first & i_select_high_second & ~i_select_low_n;
  assign pick     = {i_reg_pick_high, i_reg_pick_low};
  assign wr_en    = selected & ~i_read_not_write;
  assign rd_en    = selected & i_read_not_write;

  // register decode by select code and access bit
  assign wr_ctl_a = wr_en & (pick == DPPA_SEL_A_CTL);
  assign wr_ctl_b = wr_en & (pick == DPPA_SEL_B_CTL);
  assign wr_dir_a = wr_en & (pick == DPPA_SEL_A_PORT) & ~ctl_a[DPPA_CTL_OUT_ACCESS];
  assign wr_out_a = wr_en & (pick == DPPA_SEL_A_PORT) & ctl_a[DPPA_CTL_OUT_ACCESS];
  assign wr_dir_b = wr_en & (pick == DPPA_SEL_B_PORT) & ~ctl_b[DPPA_CTL_OUT_ACCESS];
  assign wr_out_b = wr_en & (pick == DPPA_SEL_B_PORT) & ctl_b[DPPA_CTL_OUT_ACCESS];
  assign rd_out_a = rd_en & (pick == DPPA_SEL_A_PORT) & ctl_a[DPPA_CTL_OUT_ACCESS];
  assign rd_out_b = rd_en & (pick == DPPA_SEL_B_PORT) & ctl_b[DPPA_CTL_OUT_ACCESS];

  // read multiplexer
  always_comb begin
    rdata_next = 8'h00;
    unique case (pick)
      DPPA_SEL_A_PORT: rdata_next = ctl_a[DPPA_CTL_OUT_ACCESS] ? rv_a : dir_a;
      DPPA_SEL_A_CTL:  rdata_next = ctl_a;
      DPPA_SEL_B_PORT: rdata_next = ctl_b[DPPA_CTL_OUT_ACCESS] ? rv_b : dir_b;
      DPPA_SEL_B_CTL:  rdata_next = ctl_b;
    endcase
  end

  // two identical, independent port sections
  dppa_port #(.WIDTH(8)) u_port_a (
    .i_mclk       (i_mclk),
    .i_sys_rst    (i_sys_rst),
    .i_wr_ctl     (wr_ctl_a),
    .i_wr_dir     (wr_dir_a),
    .i_wr_out     (wr_out_a),
    .i_rd_out     (rd_out_a),
    .i_wdata      (i_data),
    .i_lines      (i_port_a_lines),
    .i_ctl_in     (i_port_a_ctl_in),
    .i_ctl_io     (i_port_a_ctl_io),
    .o_ctl        (ctl_a),
    .o_dir        (dir_a),
    .o_out        (out_a),
    .o_read_value (rv_a),
    .o_irq_n      (irq_a_n)
  );
  dppa_port #(.WIDTH(8)) u_port_b (
    .i_mclk       (i_mclk),
    .i_sys_rst    (i_sys_rst),
    .i_wr_ctl     (wr_ctl_b),
    .i_wr_dir     (wr_dir_b),
    .i_wr_out     (wr_out_b),
    .i_rd_out     (rd_out_b),
    .i_wdata      (i_data),
    .i_lines      (i_port_b_lines),
    .i_ctl_in     (i_port_b_ctl_in),
    .i_ctl_io     (i_port_b_ctl_io),
    .o_ctl        (ctl_b),
    .o_dir        (dir_b),
    .o_out        (out_b),
    .o_read_value (rv_b),
    .o_irq_n      (irq_b_n)
  );

  // data bus: registered answer, driven one cycle after a selected read
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_data      <= 8'h00;
      o_data_oe_n <= 1'b1;
    end else begin
      o_data      <= rd_en ? rdata_next : 8'h00;
      o_data_oe_n <= ~rd_en;
    end
  end

  // port pins follow registers with one more flop so outputs are registered
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_port_a_lines      <= 8'h00;
      o_port_a_lines_oe_n <= 8'hff;
      o_port_b_lines      <= 8'h00;
      o_port_b_lines_oe_n <= 8'hff;
    end else begin
      o_port_a_lines      <= out_a;
      o_port_a_lines_oe_n <= ~dir_a;
      o_port_b_lines      <= out_b;
      o_port_b_lines_oe_n <= ~dir_b;
    end
  end

  // each port has its own request pin
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_port_a_irq_n <= 1'b1;
      o_port_b_irq_n <= 1'b1;
    end else begin
      o_port_a_irq_n <= irq_a_n;
      o_port_b_irq_n <= irq_b_n;
    end
  end

  release_bus_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !selected |=> o_data_oe_n)
    else $error("data bus driven while unselected");
  read_data_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (rd_en && pick == DPPA_SEL_A_CTL) |=> (!o_data_oe_n && o_data == $past(ctl_a)))
    else $error("control A read wrong");
  ctl_write_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_ctl_b |=> (ctl_b[5:0] == $past(i_data[5:0])))
    else $error("control B write lost");
  dir_write_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_dir_a |=> ##1 (o_port_a_lines_oe_n == ~$past(i_data, 2)))
    else $error("direction A not applied");
  access_sel_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (wr_en && pick == DPPA_SEL_A_PORT && !ctl_a[2]) |=> $stable(out_a))
    else $error("output A written via direction");
  write_quiet_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_en |=> o_data_oe_n)
    else $error("data bus driven on write");
  reset_clear_a: assert property (@(posedge i_mclk)
    i_sys_rst |=> (ctl_a == 8'h00 && dir_b == 8'h00 && o_port_b_lines_oe_n == 8'hff))
    else $error("reset did not clear");

  // read answers for every register the pick code and access bit can reach
  ctl_b_read_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (rd_en && pick == DPPA_SEL_B_CTL) |=> (!o_data_oe_n && o_data == $past(ctl_b)))
    else $error("control B read wrong");
  dir_a_read_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (rd_en && pick == DPPA_SEL_A_PORT && !ctl_a[DPPA_CTL_OUT_ACCESS]) |=>
      (o_data == $past(dir_a)))
    else $error("direction A read wrong");
  dir_b_read_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (rd_en && pick == DPPA_SEL_B_PORT && !ctl_b[DPPA_CTL_OUT_ACCESS]) |=>
      (o_data == $past(dir_b)))
    else $error("direction B read wrong");
  // output reads split per line kind: driven lines echo the register, others the pins
  port_a_read_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (rd_en && pick == DPPA_SEL_A_PORT && ctl_a[DPPA_CTL_OUT_ACCESS]) |=>
      ((o_data & $past(dir_a)) == ($past(out_a) & $past(dir_a)) &&
       (o_data & ~$past(dir_a)) == ($past(i_port_a_lines) & ~$past(dir_a))))
    else $error("port A read wrong");
  port_b_read_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (rd_en && pick == DPPA_SEL_B_PORT && ctl_b[DPPA_CTL_OUT_ACCESS]) |=>
      ((o_data & $past(dir_b)) == ($past(out_b) & $past(dir_b)) &&
       (o_data & ~$past(dir_b)) == ($past(i_port_b_lines) & ~$past(dir_b))))
    else $error("port B read wrong");
  read_drive_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    rd_en |=> !o_data_oe_n)
    else $error("selected read not driven");

  // writes reach the pins two edges later, through the register and the pin flop
  dir_b_apply_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_dir_b |=> ##1 (o_port_b_lines_oe_n == ~$past(i_data, 2)))
    else $error("direction B not applied");
  out_a_apply_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_out_a |=> ##1 (o_port_a_lines == $past(i_data, 2)))
    else $error("output A not applied");
  out_b_apply_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_out_b |=> ##1 (o_port_b_lines == $past(i_data, 2)))
    else $error("output B not applied");
  b_access_sel_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (wr_en && pick == DPPA_SEL_B_PORT && !ctl_b[DPPA_CTL_OUT_ACCESS]) |=> $stable(out_b))
    else $error("output B written via direction");
  ctl_a_update_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_ctl_a |=> (ctl_a[5:0] == $past(i_data[5:0])))
    else $error("control A write lost");
  unselect_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !selected |=> ($stable(ctl_a[5:0]) && $stable(ctl_b[5:0]) && $stable(dir_a) &&
                   $stable(dir_b) && $stable(out_a) && $stable(out_b)))
    else $error("register changed while unselected");

  // requests pass two flops: the port's own and the pin flop here
  irq_a_path_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (ctl_a[DPPA_CTL_FLAG_FIRST] && ctl_a[DPPA_CTL_IN_ENABLE]) |=> ##1 !o_port_a_irq_n)
    else $error("request A not on pin");
  irq_b_path_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (ctl_b[DPPA_CTL_FLAG_SECOND] && ctl_b[DPPA_CTL_IO_ENABLE]) |=> ##1 !o_port_b_irq_n)
    else $error("request B not on pin");
  irq_b_quiet_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ((!ctl_b[DPPA_CTL_FLAG_FIRST] || !ctl_b[DPPA_CTL_IN_ENABLE]) &&
     (!ctl_b[DPPA_CTL_FLAG_SECOND] || !ctl_b[DPPA_CTL_IO_ENABLE])) |=> ##1 o_port_b_irq_n)
    else $error("masked request B raised");
  reset_quiet_a: assert property (@(posedge i_mclk)
    i_sys_rst |=> (o_data_oe_n && o_data == 8'h00 && o_port_a_irq_n && o_port_b_irq_n))
    else $error("reset left bus or request active");
endmodule

// File: sim/dppa_periph.sv
`timescale 1ns/10ps
// peripheral device on one port: drives its own pattern where the port listens
module dppa_periph (
  input  wire logic [7:0] i_pattern,
  input  wire logic [7:0] i_port_lines,
  input  wire logic [7:0] i_port_oe_n,
  output logic      [7:0] o_pin_level
);
  // wire level per line: the port wins where it drives, the peripheral elsewhere
  // a line is never left floating, so no unknown can reach the port input
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      o_pin_level[k] = i_port_oe_n[k] ? i_pattern[k] : i_port_lines[k];
    end
  end
endmodule

// File: sim/dppa_top_test.sv
`timescale 1ns/10ps
// register level checks of the two-port adapter through its own bus cycles
module dppa_top_test
  import dppa_pkg::*;
;
  logic       i_mclk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       i_select_high_first = 1'b0;
  logic       i_select_high_second = 1'b0;
  logic       i_select_low_n = 1'b1;
  logic       i_read_not_write = 1'b1;
  logic       i_reg_pick_low = 1'b0;
  logic       i_reg_pick_high = 1'b0;
  logic [7:0] i_data = 8'h00;
  logic [3:0] ctl = 4'h0;
  logic [7:0] o_data, i_port_a_lines, i_port_b_lines, out_a, out_b, oe_a, oe_b, rdata;
  logic       o_data_oe_n, irq_a_n, irq_b_n, roe;
  logic [2:0] bad [3] = '{3'b010, 3'b100, 3'b111};
  int         errors = 0;
  int         n_compared = 0;

  dppa_top i_dppa_top (.i_mclk, .i_sys_rst, .i_select_high_first, .i_select_high_second,
    .i_select_low_n, .i_read_not_write, .i_reg_pick_low, .i_reg_pick_high, .i_data, .o_data,
    .o_data_oe_n, .i_port_a_lines, .o_port_a_lines(out_a), .o_port_a_lines_oe_n(oe_a),
    .i_port_b_lines, .o_port_b_lines(out_b), .o_port_b_lines_oe_n(oe_b),
    .i_port_a_ctl_in(ctl[0]), .i_port_a_ctl_io(ctl[1]), .i_port_b_ctl_in(ctl[2]),
    .i_port_b_ctl_io(ctl[3]), .o_port_a_irq_n(irq_a_n), .o_port_b_irq_n(irq_b_n));
  dppa_periph i_dppa_periph_a (.i_pattern(8'h3c), .i_port_lines(out_a),
    .i_port_oe_n(oe_a), .o_pin_level(i_port_a_lines));
  dppa_periph i_dppa_periph_b (.i_pattern(8'hc3), .i_port_lines(out_b),
    .i_port_oe_n(oe_b), .o_pin_level(i_port_b_lines));

  // 50 MHz bus clock
  initial begin
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus cycle; the answer is taken at the falling edge after the taking edge
  task automatic access(input logic rnw, input logic [1:0] pk, input logic [7:0] wd,
                        input logic [2:0] sel);
    @(negedge i_mclk);
    {i_select_high_first, i_select_high_second, i_select_low_n} = sel;
    i_read_not_write = rnw;
    {i_reg_pick_high, i_reg_pick_low} = pk;
    i_data = wd;
    @(negedge i_mclk);
    rdata = o_data;
    roe = o_data_oe_n;
    {i_select_high_first, i_select_high_second, i_select_low_n} = 3'b001;
    i_read_not_write = 1'b1;
    i_data = ~wd;  // released bus must not look like the last byte
  endtask

  task automatic wr(input logic [1:0] pk, input logic [7:0] wd);
    access(1'b0, pk, wd, 3'b110);
    cmp({7'h0, roe}, 8'h01);
  endtask

  task automatic rd(input logic [1:0] pk, input logic [7:0] exp);
    access(1'b1, pk, 8'h00, 3'b110);
    cmp({7'h0, roe}, 8'h00);
    cmp(rdata, exp);
  endtask

  task automatic do_reset();
    @(negedge i_mclk);
    i_sys_rst = 1'b1;
    repeat (10) @(negedge i_mclk);
    i_sys_rst = 1'b0;
  endtask

  // control line change, then enough edges for the two request flops
  task automatic ev(input int idx, input logic lvl);
    @(negedge i_mclk);
    ctl[idx] = lvl;
    repeat (4) @(negedge i_mclk);
  endtask

  // watchdog: the whole sequence needs about 134 cycles
  initial begin
    repeat (3000) @(posedge i_mclk);
    errors++;
    report_and_stop();
  end

  initial begin
    do_reset();
    cmp(oe_a & oe_b, 8'hff);
    cmp({6'h0, irq_a_n, irq_b_n}, 8'h03);
    rd(DPPA_SEL_A_CTL, 8'h00);
    rd(DPPA_SEL_B_CTL, 8'h00);
    rd(DPPA_SEL_B_PORT, 8'h00);
    wr(DPPA_SEL_A_CTL, 8'hff);
    rd(DPPA_SEL_A_CTL, 8'h3f);
    wr(DPPA_SEL_A_CTL, 8'h00);
    wr(DPPA_SEL_A_PORT, 8'hf0);
    rd(DPPA_SEL_A_PORT, 8'hf0);
    wr(DPPA_SEL_A_CTL, 8'h04);
    wr(DPPA_SEL_A_PORT, 8'ha5);
    rd(DPPA_SEL_A_PORT, 8'hac);
    cmp(oe_a, 8'h0f);
    cmp(i_port_a_lines, 8'hac);
    wr(DPPA_SEL_B_PORT, 8'h0f);
    rd(DPPA_SEL_B_PORT, 8'h0f);
    wr(DPPA_SEL_B_CTL, 8'h04);
    wr(DPPA_SEL_B_PORT, 8'h5a);
    rd(DPPA_SEL_B_PORT, 8'hca);
    cmp(oe_b, 8'hf0);
    rd(DPPA_SEL_A_PORT, 8'hac);
    // each select line set wrong on its own must leave registers and the bus alone
    foreach (bad[k]) begin
      access(1'b0, DPPA_SEL_A_CTL, 8'h3b, bad[k]);
      access(1'b1, DPPA_SEL_A_CTL, 8'h00, bad[k]);
      cmp({7'h0, roe}, 8'h01);
    end
    rd(DPPA_SEL_A_CTL, 8'h04);
    // first line of port A, falling edge picked, request enabled
    wr(DPPA_SEL_A_CTL, 8'h05);
    ev(0, 1'b1);
    rd(DPPA_SEL_A_CTL, 8'h05);
    ev(0, 1'b0);
    cmp({6'h0, irq_a_n, irq_b_n}, 8'h01);
    rd(DPPA_SEL_A_CTL, 8'h85);
    rd(DPPA_SEL_A_PORT, 8'hac);
    rd(DPPA_SEL_A_CTL, 8'h05);
    cmp({7'h0, irq_a_n}, 8'h01);
    // second line of port A, rising edge, then masked by a control write
    wr(DPPA_SEL_A_CTL, 8'h1c);
    ev(1, 1'b1);
    cmp({7'h0, irq_a_n}, 8'h00);
    wr(DPPA_SEL_A_CTL, 8'h14);
    rd(DPPA_SEL_A_CTL, 8'h54);
    cmp({7'h0, irq_a_n}, 8'h01);
    rd(DPPA_SEL_A_PORT, 8'hac);
    rd(DPPA_SEL_A_CTL, 8'h14);
    // first line of port B with the rising edge picked
    wr(DPPA_SEL_B_CTL, 8'h07);
    ev(2, 1'b1);
    cmp({6'h0, irq_a_n, irq_b_n}, 8'h02);
    rd(DPPA_SEL_B_CTL, 8'h87);
    // second line of port B, falling edge, first flag left set but masked
    wr(DPPA_SEL_B_CTL, 8'h08);
    ev(3, 1'b1);
    cmp({6'h0, irq_a_n, irq_b_n}, 8'h03);
    ev(3, 1'b0);
    cmp({6'h0, irq_a_n, irq_b_n}, 8'h02);
    rd(DPPA_SEL_B_PORT, 8'h0f);
    rd(DPPA_SEL_B_CTL, 8'hc8);
    // reset in mid-run returns the registers to zero and releases the port lines
    do_reset();
    rd(DPPA_SEL_B_CTL, 8'h00);
    rd(DPPA_SEL_A_PORT, 8'h00);
    cmp(oe_a & oe_b, 8'hff);
    report_and_stop();
  end
endmodule
